// >>> dv/tb_top.sv
// Purpose: Status bank bench
// Assumes: Host model runs bus cycles
// Notes:   Inputs move at falling edge
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic       clk_sys_in = 1'b0, reset_n_in = 1'b0, cs_n, rd_n, wr_n, oe_n, pos = 1'b1, stb = 1'b0;
   logic       ev = 1'b0, em = 1'b0, neg = 1'b0, fv = 1'b0, fe = 1'b0;
   logic [7:0] ad, wd, rd, q, req = 8'h00;
   int         bad_count = 0, check_count = 0;
   tfs_status_bank u_dut (.clk_sys_in, .reset_n_in, .cs_n_in(cs_n), .rd_n_in(rd_n), .wr_n_in(wr_n), .addr_in(ad),
      .data_in(wd), .data_out(rd), .data_oe_n_out(oe_n), .rx_line_positive_in(pos), .rx_line_negative_in(neg),
      .rx_bit_strobe_in(stb), .rx_buffer_full_event_in(ev), .rx_buffer_empty_event_in(em), .frame_bit_valid_in(fv),
      .frame_bit_error_in(fe), .framer0_status_request_in(req[0]), .framer0_link_ctrl_request_in(req[1]),
      .framer1_status_request_in(req[2]), .framer1_link_ctrl_request_in(req[3]), .framer2_status_request_in(req[4]),
      .framer2_link_ctrl_request_in(req[5]), .framer3_status_request_in(req[6]), .framer3_link_ctrl_request_in(req[7]));
   tfs_host u_host (.clk_sys_in, .oe_n_in(oe_n), .rd_in(rd), .cs_n_out(cs_n), .rd_n_out(rd_n), .wr_n_out(wr_n),
      .a_out(ad), .d_out(wd));
   initial forever #12.5 clk_sys_in = ~clk_sys_in;
   task automatic t(input logic [7:0] a, m, e);
      if (a == 8'h22) u_host.poll(m, q);
      else u_host.acc(1'b0, a, 8'h00, q);
      check_count++;
      if (q !== e) begin
         bad_count++;
         $display("[ERR] read of %h expected %h seen %h", a, e, q);
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic zeros(input int n, input logic b);
      for (int i = 0; i <= n; i++) begin
         {pos, neg} = (i == n) ? {!b, b} : 2'h0;
         repeat (2) @(negedge clk_sys_in);
         stb = 1'b1;
         repeat (3) @(negedge clk_sys_in) stb = 1'b0;
      end
   endtask
   task automatic fb(input logic [13:0] p);
      for (int i = 0; i < 14; i++) begin
         {fv, fe} = {1'b1, p[i]};
         @(negedge clk_sys_in) fv = 1'b0;
         @(negedge clk_sys_in);
      end
   endtask
   initial begin
      repeat (8) @(negedge clk_sys_in);
      reset_n_in = 1'b1;
      repeat (6) @(negedge clk_sys_in);
      t(8'h22, 8'hff, 8'h00);
      for (int i = 0; i < 4; i++) begin
         req = {4{i[1:0]}};
         t(req | 8'ha0, 8'h00, req);
      end
      for (int i = 0; i < 8; i++) begin
         req = 8'h01 << i;
         t(req | 8'ha0, 8'h00, req);
      end
      t(8'h9f, 8'h00, 8'h00);
      fb(14'h0040);
      ev = 1'b1;
      @(negedge clk_sys_in) ev = 1'b0;
      t(8'h22, 8'hff, 8'h11);
      em = 1'b1;
      @(negedge clk_sys_in) em = 1'b0;
      fb(14'h0840);
      t(8'h22, 8'hff, 8'h0d);
      fb(14'h1040);
      t(8'h22, 8'hff, 8'h01);
      zeros(16, 1'b0);
      t(8'h22, 8'h20, 8'h20);
      t(8'h22, 8'hff, 8'h40);
      zeros(7, 1'b1);
      t(8'h22, 8'hff, 8'h00);
      zeros(8, 1'b0);
      t(8'h22, 8'hff, 8'h40);
      final_report;
   end
   initial begin
      repeat (20000) @(posedge clk_sys_in);
      bad_count++;
      final_report;
   end
endmodule // tb_top
`default_nettype wire

// >>> dv/tfs_chk_checker.sv
// Purpose: Port checks of the status bank
// Assumes: Host strobes held 8 cycles
// Notes:   Bound at foot
`timescale 1ns/10ps
`default_nettype none
module tfs_chk (
   input wire logic       clk_sys_in, reset_n_in, rd_n_in, data_oe_n_out,
   input wire logic       framer0_status_request_in, framer0_link_ctrl_request_in, framer1_status_request_in,
   input wire logic       framer1_link_ctrl_request_in, framer2_status_request_in, framer2_link_ctrl_request_in,
   input wire logic       framer3_status_request_in, framer3_link_ctrl_request_in,
   input wire logic [7:0] addr_in, data_out
);
   wire [7:0] req_w = {framer3_link_ctrl_request_in, framer3_status_request_in, framer2_link_ctrl_request_in,
      framer2_status_request_in, framer1_link_ctrl_request_in, framer1_status_request_in,
      framer0_link_ctrl_request_in, framer0_status_request_in};
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!reset_n_in);
   property p_un; $fell(data_oe_n_out) && addr_in < 8'ha0 && addr_in != 8'h22 |-> data_out == 8'h00; endproperty
   a_un: assert property (p_un) else $error("unmapped");
   property p_rs; $fell(data_oe_n_out) && addr_in == 8'h22 |-> !data_out[7] && !data_out[1]; endproperty
   a_rs: assert property (p_rs) else $error("spare");
   property p_ca; $fell(data_oe_n_out) |-> !$past(rd_n_in, 3); endproperty
   a_ca: assert property (p_ca) else $error("cause");
   property p_an; $fell(rd_n_in) ##1 !rd_n_in [*7] |-> !data_oe_n_out; endproperty
   a_an: assert property (p_an) else $error("answer");
   property p_id; rd_n_in [*8] |-> data_oe_n_out; endproperty
   a_id: assert property (p_id) else $error("idle");
   property p_st; $fell(data_oe_n_out) |=> !data_oe_n_out [*3]; endproperty
   a_st: assert property (p_st) else $error("short");
   property p_ch; $changed(data_out) |-> $fell(data_oe_n_out); endproperty
   a_ch: assert property (p_ch) else $error("moved");
   property p_re; $rose(data_oe_n_out) |-> rd_n_in; endproperty
   a_re: assert property (p_re) else $error("release");
   property p_sm; $fell(data_oe_n_out) && addr_in >= 8'ha0 |-> data_out == $past(req_w); endproperty
   a_sm: assert property (p_sm) else $error("summary");
endmodule // tfs_chk
bind tfs_status_bank tfs_chk u_chk (.clk_sys_in, .reset_n_in, .rd_n_in, .data_oe_n_out, .addr_in, .data_out,
   .framer0_status_request_in, .framer0_link_ctrl_request_in, .framer1_status_request_in,
   .framer1_link_ctrl_request_in, .framer2_status_request_in, .framer2_link_ctrl_request_in,
   .framer3_status_request_in, .framer3_link_ctrl_request_in);
`default_nettype wire

// >>> dv/tfs_host.sv
// Purpose: Host processor on the parallel port
// Assumes: Strobes held 8 cycles low and high
// Notes:   Undriven data reads back inverted
`timescale 1ns/10ps
`default_nettype none
module tfs_host (
   input  wire logic       clk_sys_in,
   input  wire logic       oe_n_in,
   input  wire logic [7:0] rd_in,
   output var  logic       cs_n_out = 1'b1,
   output var  logic       rd_n_out = 1'b1,
   output var  logic       wr_n_out = 1'b1,
   output var  logic [7:0] a_out    = 8'h00,
   output var  logic [7:0] d_out    = 8'h00
);
   task automatic acc(input logic w, input logic [7:0] a, d, output logic [7:0] q);
      @(negedge clk_sys_in);
      {cs_n_out, wr_n_out, rd_n_out, a_out} = {1'b0, !w, w, a};
      d_out = w ? d : ~d_out;
      repeat (8) @(negedge clk_sys_in);
      q = oe_n_in ? ~rd_in : rd_in;
      {wr_n_out, rd_n_out} = 2'h3;
      repeat (8) @(negedge clk_sys_in);
      {cs_n_out, a_out} = {1'b1, ~a};
   endtask
   task automatic poll(input logic [7:0] m, output logic [7:0] q);
      logic [7:0] x;
      acc(1'b1, 8'h22, m, x);
      acc(1'b0, 8'h22, 8'h00, q);
      acc(1'b1, 8'h22, q & m, x);
   endtask
endmodule // tfs_host
`default_nettype wire

// >>> logic/tfs_map.vh
// Purpose: Offsets, field positions, reset values and counts of the status bank
// Assumes: Eight-bit host address and data
// Notes:   Definitions only
`ifndef TFS_MAP_VH
`define TFS_MAP_VH

`define TFS_ADDR_EVT_ONE     8'h22
`define TFS_ADDR_SUM_LO      8'ha0
`define TFS_ADDR_SUM_HI      8'hff

`define TFS_BIT_EIGHT_ZERO   6
`define TFS_BIT_SIXTEEN_ZERO 5
`define TFS_BIT_BUF_FULL     4
`define TFS_BIT_BUF_EMPTY    3
`define TFS_BIT_SEVERE_FRM   2
`define TFS_BIT_FRM_BIT_ERR  0

`define TFS_EVT_RESET        8'h00
`define TFS_DATA_IDLE        8'h00

`define TFS_ZERO_SHORT       5'h08
`define TFS_ZERO_LONG        5'h10
`define TFS_SEF_WINDOW       6
`define TFS_SEF_ERRORS       3'h2

`endif

// >>> logic/tfs_pin_sync.v
// Purpose: Three-stage synchroniser for pin inputs
// Assumes: Inputs asynchronous to clk_sys_in
// Notes:   Output moves once stages two and three agree
`timescale 1ns/10ps
`default_nettype none

module tfs_pin_sync #(
   parameter W = 1
) (
   input  wire         clk_sys_in,
   input  wire         reset_n_in,
   input  wire [W-1:0] pin_in,
   input  wire [W-1:0] rst_val_in,
   output reg  [W-1:0] level_out
);

   reg [W-1:0] s1_r;
   reg [W-1:0] s2_r;
   reg [W-1:0] s3_r;
   integer     i;

   always @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         s1_r      <= rst_val_in;
         s2_r      <= rst_val_in;
         s3_r      <= rst_val_in;
         level_out <= rst_val_in;
      end else begin
         s1_r <= pin_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         for (i = 0; i < W; i = i + 1) begin
            if (s2_r[i] == s3_r[i]) begin
               level_out[i] <= s3_r[i];
            end
         end
      end
   end

endmodule // tfs_pin_sync

`default_nettype wire

// >>> logic/tfs_status_bank.v
// Purpose: Framer interrupt summary and receive event flag register
// Assumes: Host parallel port with active-low select, read and write strobes
// Notes:   Address and data are taken when the write strobe is seen to rise
//
// What this block does
// - Any read address from a0 to ff returns the interrupt summary byte.
// - Summary bit 2n shows framer n status-register interrupt request pending.
// - Summary bit 2n+1 shows framer n link controller interrupt request pending.
// - Receive event flag register one sits at address 22.
// - Bit 5 sets once a zero run reaches sixteen, any run length.
// - Bit 4 sets when receive elastic buffer overflows and drops a frame.
// - Bit 2 sets when two of any six framing bits are in error.
// - Bit 0 sets on every single framing bit error.
// - Flags stay latched until the host reads them, then clear until recurring.
// - Host writes a mask first; only masked-in bits refresh, others hold.
`timescale 1ns/10ps
`default_nettype none
`include "tfs_map.vh"

module tfs_status_bank (
   input  wire       clk_sys_in,
   input  wire       reset_n_in,
   input  wire       cs_n_in,
   input  wire       rd_n_in,
   input  wire       wr_n_in,
   input  wire [7:0] addr_in,
   input  wire [7:0] data_in,
   output reg  [7:0] data_out,
   output reg        data_oe_n_out,
   input  wire       framer0_status_request_in,
   input  wire       framer1_status_request_in,
   input  wire       framer2_status_request_in,
   input  wire       framer3_status_request_in,
   input  wire       framer0_link_ctrl_request_in,
   input  wire       framer1_link_ctrl_request_in,
   input  wire       framer2_link_ctrl_request_in,
   input  wire       framer3_link_ctrl_request_in,
   input  wire       rx_line_positive_in,
   input  wire       rx_line_negative_in,
   input  wire       rx_bit_strobe_in,
   input  wire       rx_buffer_full_event_in,
   input  wire       rx_buffer_empty_event_in,
   input  wire       frame_bit_valid_in,
   input  wire       frame_bit_error_in
);

   function [2:0] ones_count;
      input [5:0] v;
      integer     k;
      begin
         ones_count = 3'h0;
         for (k = 0; k < 6; k = k + 1) begin
            ones_count = ones_count + {2'h0, v[k]};
         end
      end
   endfunction

   function evt_one_hit;
      input [7:0] a;
      begin
         evt_one_hit = (a == `TFS_ADDR_EVT_ONE);
      end
   endfunction

   function run_reaches;
      input [4:0] cur;
      input [4:0] nxt;
      input [4:0] lim;
      begin
         run_reaches = (nxt == lim) && (cur != lim);
      end
   endfunction

   wire [4:0] pins_q;
   reg        rd_q_r;
   reg        wr_q_r;
   reg  [3:0] strb_d_r;
   reg  [4:0] zero_cnt_r;
   reg  [4:0] zero_cnt_nxt;
   reg  [5:0] fhist_r;
   reg  [5:0] fhist_nxt;
   reg  [7:0] flags_r;
   reg  [7:0] flags_nxt;
   reg  [7:0] snap_r;
   reg  [7:0] mask_r;
   reg  [1:0] zero_set;
   reg  [1:0] frm_set;
   reg  [7:0] set_v;
   reg  [7:0] summary;
   reg  [7:0] rdata;
   wire       sel_n;
   wire       rd_fall;
   wire       rd_rise;
   wire       wr_rise;
   wire       line_zero;
   wire       rd_lvl;
   wire       wr_lvl;
   wire       pos_lvl;
   wire       neg_lvl;
   wire       evt_hit;

   // Pin inputs: select, read, write, line bits
   tfs_pin_sync #(
      .W (5)
   ) u_sync (
      .clk_sys_in (clk_sys_in),
      .reset_n_in (reset_n_in),
      .pin_in     ({cs_n_in, rd_n_in, wr_n_in, rx_line_positive_in, rx_line_negative_in}),
      .rst_val_in (5'h1f),
      .level_out  (pins_q)
   );

   assign sel_n     = pins_q[4];
   assign rd_lvl    = pins_q[3];
   assign wr_lvl    = pins_q[2];
   assign pos_lvl   = pins_q[1];
   assign neg_lvl   = pins_q[0];
   assign evt_hit   = evt_one_hit(addr_in);
   assign rd_fall   = rd_q_r & ~rd_lvl & ~sel_n;
   assign rd_rise   = ~rd_q_r & rd_lvl;
   assign wr_rise   = ~wr_q_r & wr_lvl & ~sel_n;
   assign line_zero = ~pos_lvl & ~neg_lvl;

   // Live request summary
   always @* begin
      summary[0] = framer0_status_request_in;
      summary[1] = framer0_link_ctrl_request_in;
      summary[2] = framer1_status_request_in;
      summary[3] = framer1_link_ctrl_request_in;
      summary[4] = framer2_status_request_in;
      summary[5] = framer2_link_ctrl_request_in;
      summary[6] = framer3_status_request_in;
      summary[7] = framer3_link_ctrl_request_in;
   end

   // Zero run counting, saturating; strobe delayed to line sync depth
   always @* begin
      zero_cnt_nxt = zero_cnt_r;
      zero_set     = 2'h0;
      if (strb_d_r[3]) begin
         if (!line_zero) begin
            zero_cnt_nxt = 5'h00;
         end else if (zero_cnt_r != `TFS_ZERO_LONG) begin
            zero_cnt_nxt = zero_cnt_r + 5'h01;
         end
         zero_set[1] = run_reaches(zero_cnt_r, zero_cnt_nxt, `TFS_ZERO_LONG);
         zero_set[0] = run_reaches(zero_cnt_r, zero_cnt_nxt, `TFS_ZERO_SHORT);
      end
   end

   // Framing bit error window
   always @* begin
      fhist_nxt = fhist_r;
      frm_set   = 2'h0;
      if (frame_bit_valid_in) begin
         fhist_nxt = {fhist_r[4:0], frame_bit_error_in};
         if (frame_bit_error_in) begin
            frm_set[0] = 1'b1;
            if (ones_count(fhist_nxt) >= `TFS_SEF_ERRORS) begin
               frm_set[1] = 1'b1;
            end
         end
      end
   end

   // Latched flags; a new event wins over the read clear
   always @* begin
      set_v                        = 8'h00;
      set_v[`TFS_BIT_EIGHT_ZERO]   = zero_set[0];
      set_v[`TFS_BIT_SIXTEEN_ZERO] = zero_set[1];
      set_v[`TFS_BIT_BUF_FULL]     = rx_buffer_full_event_in;
      set_v[`TFS_BIT_BUF_EMPTY]    = rx_buffer_empty_event_in;
      set_v[`TFS_BIT_SEVERE_FRM]   = frm_set[1];
      set_v[`TFS_BIT_FRM_BIT_ERR]  = frm_set[0];
      flags_nxt = flags_r | set_v;
      if (rd_fall && evt_hit) begin
         flags_nxt = (flags_r & ~(snap_r & mask_r)) | set_v;
      end
   end

   // Read data select
   always @* begin
      if (addr_in >= `TFS_ADDR_SUM_LO) begin
         rdata = summary;
      end else if (evt_hit) begin
         rdata = snap_r;
      end else begin
         rdata = `TFS_DATA_IDLE;
      end
   end

   always @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         rd_q_r        <= 1'b1;
         wr_q_r        <= 1'b1;
         strb_d_r      <= 4'h0;
         zero_cnt_r    <= 5'h00;
         fhist_r       <= 6'h00;
         flags_r       <= `TFS_EVT_RESET;
         snap_r        <= `TFS_EVT_RESET;
         mask_r        <= `TFS_EVT_RESET;
         data_out      <= `TFS_DATA_IDLE;
         data_oe_n_out <= 1'b1;
      end else begin
         rd_q_r     <= pins_q[3];
         wr_q_r     <= pins_q[2];
         strb_d_r   <= {strb_d_r[2:0], rx_bit_strobe_in};
         zero_cnt_r <= zero_cnt_nxt;
         fhist_r    <= fhist_nxt;
         flags_r    <= flags_nxt;
         if (wr_rise && evt_hit) begin
            mask_r <= data_in;
            snap_r <= (snap_r & ~data_in) | ((flags_r | set_v) & data_in);
         end
         if (rd_fall) begin
            data_out      <= rdata;
            data_oe_n_out <= 1'b0;
         end else if (rd_rise || sel_n) begin
            data_oe_n_out <= 1'b1;
         end
      end
   end

endmodule // tfs_status_bank

`default_nettype wire
